// File: odc_core.sv
/*
  Output drive calibration: calibration packets, current sampling and
  temperature slew adjust. Link logic runs on clk_link; settings are
  handed to clk_sys by a toggle handshake.
  Assumes the controller addresses packets correctly and keeps its spacing.
*/
`timescale 1ns/1ns
`default_nettype none
`include "odc_regs.svh"
module odc_core
  import odc_pkg::*;
#(
  parameter int DELAY = 8,
  parameter logic [`ODC_CUR_W-1:0] CUR_RESET = `ODC_CUR_RESET,
  parameter logic [`ODC_SLEW_W-1:0] SLEW_RESET = `ODC_SLEW_RESET
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_link,
  input wire odc_col_type col_in,
  input wire odc_row_type row_in,
  input wire logic write_req,
  input wire logic temp_sense_flag,
  input wire logic [1:0] cal_sense,
  output odc_lanes_type lanes_out,
  output odc_lanes_type lanes_oe,
  output logic write_accept,
  output logic read_block,
  output logic [`ODC_CUR_W-1:0] output_low_current,
  output logic [`ODC_SLEW_W-1:0] output_slew_rate
);
  // Link reset: asynchronous assert, synchronous release
  logic lrst_meta_reg, lrst_b_reg;
  always_ff @(posedge clk_link or negedge rst_b) begin
    if (!rst_b) begin
      lrst_meta_reg <= 1'b0;
      lrst_b_reg <= 1'b0;
    end else begin
      lrst_meta_reg <= 1'b1;
      lrst_b_reg <= lrst_meta_reg;
    end
  end

  // Flag from clk_sys domain synchronised into link domain
  logic tsq_meta_reg, tsq_reg;
  always_ff @(posedge clk_link or negedge lrst_b_reg) begin
    if (!lrst_b_reg) begin
      tsq_meta_reg <= 1'b0;
      tsq_reg <= 1'b0;
    end else begin
      tsq_meta_reg <= temp_sense_flag;
      tsq_reg <= tsq_meta_reg;
    end
  end

  // Accept only addressed calibrate commands
  wire col_cal = col_in.valid && col_in.cal && !col_in.bcast;
  wire col_sam = col_cal && col_in.sample_cmd;
  wire [1:0] dly_q;
  odc_delay #(.DEPTH(DELAY)) u_delay (
    .clk(clk_link),
    .rst_b(lrst_b_reg),
    .d({col_cal, col_sam}),
    .q(dly_q)
  );
  wire pkt_now = dly_q[1];
  wire pkt_sam = dly_q[0];

  // Calibration packet drive
  odc_lanes_type lanes_next, oe_next;
  always_comb begin
    lanes_next = '0;
    oe_next = '0;
    if (pkt_now) begin
      lanes_next.lane_a[`ODC_CAL_BIT_HI:`ODC_CAL_BIT_LO] = 2'b10;
      lanes_next.lane_b[`ODC_CAL_BIT_HI:`ODC_CAL_BIT_LO] = 2'b10;
      oe_next.lane_a[`ODC_CAL_BIT_HI:`ODC_CAL_BIT_LO] = 2'b11;
      oe_next.lane_b[`ODC_CAL_BIT_HI:`ODC_CAL_BIT_LO] = 2'b11;
      lanes_next.lane_a[`ODC_TSENSE_BIT] = tsq_reg;
      oe_next.lane_a[`ODC_TSENSE_BIT] = 1'b1;
    end
  end
  always_ff @(posedge clk_link or negedge lrst_b_reg) begin
    if (!lrst_b_reg) begin
      lanes_out <= '0;
      lanes_oe <= '0;
    end else begin
      lanes_out <= lanes_next;
      lanes_oe <= oe_next;
    end
  end

  // Current setting steps by sampled comparator direction
  function automatic logic [`ODC_CUR_W-1:0] step_cur(input logic [`ODC_CUR_W-1:0] c,
                                                     input logic [1:0] s);
    logic [`ODC_CUR_W-1:0] r;
    r = c;
    if (s == 2'b01 && c != '1) begin
      r = c + `ODC_CUR_W'(1);
    end else if (s == 2'b10 && c != '0) begin
      r = c - `ODC_CUR_W'(1);
    end
    return r;
  endfunction

  logic [`ODC_CUR_W-1:0] cur_link_reg;
  logic sam_d_reg, cur_tog_reg;
  always_ff @(posedge clk_link or negedge lrst_b_reg) begin
    if (!lrst_b_reg) begin
      sam_d_reg <= 1'b0;
      cur_link_reg <= CUR_RESET;
      cur_tog_reg <= 1'b0;
    end else begin
      sam_d_reg <= pkt_sam;
      if (sam_d_reg) begin
        cur_link_reg <= step_cur(cur_link_reg, cal_sense);
        cur_tog_reg <= ~cur_tog_reg;
      end
    end
  end

  // Temperature sequence on row ops
  odc_temp_type temp_reg, temp_next;
  logic [7:0] quiet_reg, quiet_next;
  logic [`ODC_SLEW_W-1:0] slew_link_reg, slew_next;
  logic slew_tog_reg;
  wire rop_en = row_in.valid && row_in.row_op_field == `ODC_ROP_TEMP_CAL_ENABLE_CMD;
  wire rop_cal = row_in.valid && row_in.row_op_field == `ODC_ROP_TEMP_CAL_CMD;
  wire slew_step = temp_reg == ODC_T_ARMED && rop_cal;
  always_comb begin
    temp_next = temp_reg;
    quiet_next = quiet_reg;
    slew_next = slew_link_reg;
    case (temp_reg)
      ODC_T_IDLE: begin
        if (rop_en) begin
          temp_next = ODC_T_ARMED;
        end
      end
      ODC_T_ARMED: begin
        if (rop_cal) begin
          temp_next = ODC_T_QUIET;
          quiet_next = `ODC_QUIET_CYCLES;
          slew_next = tsq_reg ? slew_link_reg + `ODC_SLEW_W'(1)
                              : slew_link_reg - `ODC_SLEW_W'(1);
        end
      end
      ODC_T_QUIET: begin
        quiet_next = quiet_reg - 8'd1;
        if (quiet_reg == 8'd1) begin
          temp_next = ODC_T_IDLE;
        end
      end
      default: begin
        temp_next = ODC_T_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_link or negedge lrst_b_reg) begin
    if (!lrst_b_reg) begin
      temp_reg <= ODC_T_IDLE;
      quiet_reg <= 8'd0;
      slew_link_reg <= SLEW_RESET;
      slew_tog_reg <= 1'b0;
    end else begin
      temp_reg <= temp_next;
      quiet_reg <= quiet_next;
      slew_link_reg <= slew_next;
      if (slew_step) begin
        slew_tog_reg <= ~slew_tog_reg;
      end
    end
  end

  // Quiet window bars reads, writes still accepted
  assign read_block = temp_reg == ODC_T_QUIET;
  assign write_accept = write_req;

  // System reset: asynchronous assert, synchronous release
  logic srst_meta_reg, srst_b_reg;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      srst_meta_reg <= 1'b0;
      srst_b_reg <= 1'b0;
    end else begin
      srst_meta_reg <= 1'b1;
      srst_b_reg <= srst_meta_reg;
    end
  end

  // Toggle handshake of settings into clk_sys
  logic [2:0] ct_sync_reg, st_sync_reg;
  always_ff @(posedge clk_sys or negedge srst_b_reg) begin
    if (!srst_b_reg) begin
      ct_sync_reg <= 3'b000;
      st_sync_reg <= 3'b000;
      output_low_current <= CUR_RESET;
      output_slew_rate <= SLEW_RESET;
    end else begin
      ct_sync_reg <= {ct_sync_reg[1:0], cur_tog_reg};
      st_sync_reg <= {st_sync_reg[1:0], slew_tog_reg};
      if (ct_sync_reg[2] != ct_sync_reg[1]) begin
        output_low_current <= cur_link_reg;
      end
      if (st_sync_reg[2] != st_sync_reg[1]) begin
        output_slew_rate <= slew_link_reg;
      end
    end
  end

  // Quiet window length monitor
  logic [7:0] qmon_reg;
  always_ff @(posedge clk_link or negedge lrst_b_reg) begin
    if (!lrst_b_reg) begin
      qmon_reg <= 8'd0;
    end else if (read_block) begin
      qmon_reg <= qmon_reg + 8'd1;
    end else begin
      qmon_reg <= 8'd0;
    end
  end

  // Checks on calibration packets
  a_pkt_delay_cal: assert property (@(posedge clk_link) disable iff (!lrst_b_reg)
    col_cal |-> ##(DELAY+1) lanes_oe.lane_a[`ODC_CAL_BIT_LO])
    else $error("late cal packet");
  a_lanes_unused: assert property (@(posedge clk_link) disable iff (!lrst_b_reg)
    lanes_oe.lane_a[2:0] == 3'b0 && lanes_oe.lane_b[2:0] == 3'b0
    && lanes_oe.lane_b[`ODC_LANE_W-1:5] == '0 && lanes_oe.lane_a[`ODC_LANE_W-1:6] == '0)
    else $error("stray lane drive");
  a_lane_pair: assert property (@(posedge clk_link) disable iff (!lrst_b_reg)
    lanes_oe.lane_a[`ODC_CAL_BIT_HI:`ODC_CAL_BIT_LO] == lanes_oe.lane_b[`ODC_CAL_BIT_HI:`ODC_CAL_BIT_LO])
    else $error("lanes drive apart");
  a_pkt_value: assert property (@(posedge clk_link) disable iff (!lrst_b_reg)
    lanes_oe.lane_a[`ODC_CAL_BIT_LO] |-> lanes_out.lane_a[`ODC_CAL_BIT_HI:`ODC_CAL_BIT_LO] == 2'b10
    && lanes_out.lane_b[`ODC_CAL_BIT_HI:`ODC_CAL_BIT_LO] == 2'b10)
    else $error("bad packet value");
  a_lanes_idle: assert property (@(posedge clk_link) disable iff (!lrst_b_reg)
    !lanes_oe.lane_a[`ODC_CAL_BIT_LO] |-> lanes_out == '0)
    else $error("data outside packet");
  a_tsense_pair: assert property (@(posedge clk_link) disable iff (!lrst_b_reg)
    lanes_oe.lane_a[`ODC_TSENSE_BIT] == lanes_oe.lane_b[`ODC_CAL_BIT_HI])
    else $error("flag not with packet");
  a_tsense_value: assert property (@(posedge clk_link) disable iff (!lrst_b_reg)
    lanes_oe.lane_a[`ODC_TSENSE_BIT] |-> lanes_out.lane_a[`ODC_TSENSE_BIT] == $past(tsq_reg))
    else $error("wrong flag value");

  // Checks on current sampling
  a_sample_update: assert property (@(posedge clk_link) disable iff (!lrst_b_reg)
    sam_d_reg |=> cur_tog_reg != $past(cur_tog_reg))
    else $error("sample not taken");
  a_cur_hold: assert property (@(posedge clk_link) disable iff (!lrst_b_reg)
    !sam_d_reg |=> cur_link_reg == $past(cur_link_reg))
    else $error("current moved without sample");

  // Checks on temperature sequence
  a_temp_cal_enable_cmd_arm: assert property (@(posedge clk_link) disable iff (!lrst_b_reg)
    temp_reg == ODC_T_IDLE && rop_en |=> temp_reg == ODC_T_ARMED)
    else $error("enable not taken");
  a_lone_temp_cal_cmd: assert property (@(posedge clk_link) disable iff (!lrst_b_reg)
    temp_reg == ODC_T_IDLE && rop_cal |=> !read_block)
    else $error("calibrate without enable");
  a_slew_hold: assert property (@(posedge clk_link) disable iff (!lrst_b_reg)
    !slew_step |=> slew_link_reg == $past(slew_link_reg))
    else $error("slew moved without calibrate");
  a_quiet_enter: assert property (@(posedge clk_link) disable iff (!lrst_b_reg)
    slew_step |=> read_block [*8])
    else $error("quiet window short");
  a_quiet_end: assert property (@(posedge clk_link) disable iff (!lrst_b_reg)
    slew_step |=> ##139 read_block ##1 !read_block)
    else $error("quiet window length");
  a_quiet_level: assert property (@(posedge clk_link) disable iff (!lrst_b_reg)
    read_block == (quiet_reg != 8'd0))
    else $error("quiet level wrong");
  a_quiet_count: assert property (@(posedge clk_link) disable iff (!lrst_b_reg)
    $fell(read_block) |-> qmon_reg == `ODC_QUIET_CYCLES)
    else $error("quiet count wrong");
  a_write_pass: assert property (@(posedge clk_link) disable iff (!lrst_b_reg)
    read_block && write_req |-> write_accept)
    else $error("write refused");

  // Checks on the crossing into clk_sys
  a_slew_cross: assert property (@(posedge clk_sys) disable iff (!srst_b_reg)
    $changed(st_sync_reg[1]) |=> output_slew_rate == $past(slew_link_reg))
    else $error("slew not carried");
  a_cur_cross: assert property (@(posedge clk_sys) disable iff (!srst_b_reg)
    $changed(ct_sync_reg[1]) |=> output_low_current == $past(cur_link_reg))
    else $error("current not carried");
endmodule
`default_nettype wire

// File: odc_regs.svh
/*
  Timing counts and field positions for the output drive calibration block.
  Assumes inclusion by odc_pkg and design files in the same folder.
*/
`ifndef ODC_REGS_SVH
`define ODC_REGS_SVH
`define ODC_CAL_BURST 3'd4
`define ODC_COL_ACCESS_DELAY 8'd8
`define ODC_LANE_W 9
`define ODC_CAL_BIT_LO 3
`define ODC_CAL_BIT_HI 4
`define ODC_TSENSE_BIT 5
`define ODC_CUR_W 6
`define ODC_SLEW_W 4
`define ODC_CUR_RESET 6'h20
`define ODC_SLEW_RESET 4'h8
`define ODC_ROP_NONE 2'h0
`define ODC_ROP_TEMP_CAL_ENABLE_CMD 2'h1
`define ODC_ROP_TEMP_CAL_CMD 2'h2
`define ODC_QUIET_CYCLES 8'd140
`endif

// File: odc_pkg.sv
/*
  Types for the output drive calibration block.
  Assumes odc_regs.svh sits in the same folder.
*/
`include "odc_regs.svh"
package odc_pkg;
  typedef struct packed {
    logic valid;
    logic bcast;
    logic cal;
    logic sample_cmd;
  } odc_col_type;
  typedef struct packed {
    logic valid;
    logic [1:0] row_op_field;
  } odc_row_type;
  typedef struct packed {
    logic [`ODC_LANE_W-1:0] lane_a;
    logic [`ODC_LANE_W-1:0] lane_b;
  } odc_lanes_type;
  typedef enum logic [1:0] {
    ODC_T_IDLE = 2'b00,
    ODC_T_ARMED = 2'b01,
    ODC_T_QUIET = 2'b10
  } odc_temp_type;
endpackage

// File: odc_delay.sv
/*
  Fixed delay line for calibration command flags on the link clock.
  Assumes a clock and active-low asynchronous reset from the instantiating module.
*/
`timescale 1ns/1ns
`default_nettype none
module odc_delay #(
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] d,
  output logic [1:0] q
);
  logic [1:0] pipe_reg [DEPTH];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        pipe_reg[i] <= 2'h0;
      end
    end else begin
      pipe_reg[0] <= d;
      for (int i = 1; i < DEPTH; i++) begin
        pipe_reg[i] <= pipe_reg[i-1];
      end
    end
  end
  assign q = pipe_reg[DEPTH-1];
endmodule
`default_nettype wire

// File: odc_ctrl_model.sv
/*
  Controller model for odc_core: column, row and write requests on the link.
  Assumes a free-running channel clock from the bench; one device on the channel.
*/
`timescale 1ns/1ns
`default_nettype none
module odc_ctrl_model
  import odc_pkg::*;
(
  input wire logic clk_link,
  output odc_col_type col_in,
  output odc_row_type row_in,
  output logic write_req,
  output logic [1:0] cal_sense
);
  // Single device, so one current transaction covers the channel
  // No read data is issued, so calibration to read spacing holds
  initial begin
    col_in = '0;
    row_in = '0;
    write_req = 1'b0;
    cal_sense = 2'b00;
  end
  task automatic cal_burst(input logic bc, input logic [1:0] sense);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_link);
      cal_sense <= sense;
      col_in <= '{1'b1, bc, 1'b1, (i == 3)};
    end
    @(negedge clk_link);
    col_in <= {1'b0, ~col_in[2:0]};
  endtask
  task automatic row_op(input logic [1:0] row_op_field);
    @(negedge clk_link);
    row_in <= '{1'b1, row_op_field};
    @(negedge clk_link);
    row_in <= '{1'b0, ~row_op_field};
  endtask
  task automatic set_write(input logic v);
    @(negedge clk_link);
    write_req <= v;
  endtask
endmodule
`default_nettype wire

// File: test_output_drive_calibration.sv
/*
  Self-checking bench for odc_core: calibration packets, sampling, slew.
  Assumes odc_ctrl_model drives the link side of the block.
*/
`timescale 1ns/1ns
`default_nettype none
`include "odc_regs.svh"
module test_output_drive_calibration;
  import odc_pkg::*;
  logic clk_sys, clk_link, rst_b, temp_sense_flag, write_req, write_accept, read_block;
  odc_col_type col_in;
  odc_row_type row_in;
  logic [1:0] cal_sense;
  odc_lanes_type lanes_out, lanes_oe;
  logic [5:0] output_low_current;
  logic [3:0] output_slew_rate;
  int err_total, samples_checked;
  odc_core dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_link(clk_link), .col_in(col_in),
    .row_in(row_in), .write_req(write_req), .temp_sense_flag(temp_sense_flag),
    .cal_sense(cal_sense), .lanes_out(lanes_out), .lanes_oe(lanes_oe),
    .write_accept(write_accept), .read_block(read_block),
    .output_low_current(output_low_current), .output_slew_rate(output_slew_rate));
  odc_ctrl_model ctrl (.clk_link(clk_link), .col_in(col_in), .row_in(row_in),
    .write_req(write_req), .cal_sense(cal_sense));
  always #20 clk_sys = ~clk_sys;
  initial begin
    clk_link = 1'b0;
    #7;
    forever #32 clk_link = ~clk_link;
  end
  task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cal_scenario(input logic bc, input logic [1:0] sense, input logic [5:0] cur);
    logic [15:0] seen;
    logic [17:0] vexp;
    seen = '0;
    vexp = {3'b000, temp_sense_flag, 5'b10000, 9'h010};
    fork
      ctrl.cal_burst(bc, sense);
      for (int i = 1; i < 16; i++) begin
        @(negedge clk_link);
        seen[i] = (lanes_oe !== '0);
        if (seen[i]) begin
          check("lanes_oe", 18'h07018, lanes_oe);
          check("lanes_out", vexp, lanes_out);
        end
      end
    join
    check("packet slots", bc ? 18'h0 : 18'h03c00, {2'b00, seen});
    repeat (8) @(negedge clk_sys);
    check("current", {12'h0, cur}, {12'h0, output_low_current});
  endtask
  task automatic temp_scenario(input logic [3:0] slew_exp);
    int n;
    ctrl.row_op(`ODC_ROP_TEMP_CAL_CMD);
    repeat (4) @(negedge clk_link);
    check("lone temp_cal_cmd", 18'h0, {17'h0, read_block});
    ctrl.row_op(`ODC_ROP_TEMP_CAL_ENABLE_CMD);
    repeat (150) @(negedge clk_link);
    ctrl.set_write(1'b1);
    ctrl.row_op(`ODC_ROP_TEMP_CAL_CMD);
    n = 0;
    while (read_block !== 1'b1 && n < 4) begin
      @(negedge clk_link);
      n++;
    end
    check("quiet start", 18'h1, {17'h0, read_block});
    n = 0;
    while (read_block === 1'b1 && n < 300) begin
      n++;
      if (n == 5) check("write_accept", 18'h1, {17'h0, write_accept});
      @(negedge clk_link);
    end
    ctrl.set_write(1'b0);
    check("quiet length", 18'd140, n[17:0]);
    check("slew", {14'h0, slew_exp}, {14'h0, output_slew_rate});
  endtask
  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    temp_sense_flag = 1'b1;
    err_total = 0;
    samples_checked = 0;
    repeat (5) @(negedge clk_sys);
    check("reset current", 18'h20, {12'h0, output_low_current});
    check("reset slew", 18'h8, {14'h0, output_slew_rate});
    check("reset oe", 18'h0, lanes_oe);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_link);
    cal_scenario(1'b0, 2'b01, 6'h21);
    @(negedge clk_sys);
    temp_sense_flag = 1'b0;
    cal_scenario(1'b1, 2'b01, 6'h21);
    cal_scenario(1'b0, 2'b10, 6'h20);
    cal_scenario(1'b0, 2'b00, 6'h20);
    temp_scenario(4'h7);
    @(negedge clk_sys);
    temp_sense_flag = 1'b1;
    temp_scenario(4'h8);
    final_report();
  end
endmodule
`default_nettype wire
